//--- aos_core.sv
// Purpose : Overflow detection and saturation for four guarded accumulators
//           and the address-unit adder, with AXI4-Lite control and status.
// Assumes : Operation strobes come from logic on aclk; one op per unit per cycle.
// Notes   : Flags are sticky; the data unit clamps at the 40-bit range.
// Notes on behaviour
// (RULE_01) Each accumulator is 40 bits: a 32-bit body and 8 guard bits 39..32.
// (RULE_02) Each accumulator has its own flag, set when an op on it overflows.
// (RULE_03) With data saturation enabled, an overflowing data result is clamped.
// (RULE_04) The accumulator flag is set on data overflow whatever the enable.
// (RULE_05) Address results raise no flag and clamp only with address saturation on.
// (RULE_06) Clamping picks the nearest limit, e.g. 7FFF or 8000 for 16 bits.
// (RULE_07) Flags stay set until software writes one to clear them.

`timescale 1ns/100ps
`default_nettype none

module aos_core (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [7:0]                   s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [7:0]                   s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // Data-unit accumulate operation
  input  wire logic                         d_op_valid,
  input  wire logic [1:0]                   d_op_acc,
  input  wire logic                         d_op_load,
  input  wire logic                         d_op_sub,
  input  wire logic [aos_pkg::ACC_W-1:0]    d_op_operand,
  // Address-unit operation
  input  wire logic                         a_op_valid,
  input  wire logic                         a_op_sub,
  input  wire logic [aos_pkg::ADDR_UW-1:0]  a_op_a,
  input  wire logic [aos_pkg::ADDR_UW-1:0]  a_op_b,
  output logic                              a_result_valid,
  output logic [aos_pkg::ADDR_UW-1:0]       a_result,
  // Status
  output logic [aos_pkg::NUM_ACC-1:0]       acc_overflow
);
  import aos_pkg::*;

  // Register index of an accumulator word, or -1 when not an accumulator
  function automatic int acc_word(input logic [7:0] addr);
    int idx;
    idx = -1;
    for (int i = 0; i < NUM_ACC; i++)
    begin
      if (addr == OFF_ACC_LO + 8'(i * ACC_STRIDE))
        idx = 2 * i;
      if (addr == OFF_ACC_HI + 8'(i * ACC_STRIDE))
        idx = 2 * i + 1;
    end
    return idx;
  endfunction

  logic [ACC_W-1:0]   acc_reg   [NUM_ACC];
  logic [ACC_W-1:0]   acc_next  [NUM_ACC];
  logic [NUM_ACC-1:0] flags_reg, flags_next;
  logic [1:0]         ctrl_reg, ctrl_next;
  logic [ADDR_UW-1:0] ares_reg, ares_next;
  logic               aval_reg, aval_next;
  logic               awh_reg, awh_next, wh_reg, wh_next;
  logic [7:0]         awa_reg, awa_next;
  logic [31:0]        wd_reg, wd_next;
  logic [3:0]         ws_reg, ws_next;
  logic               bv_reg, bv_next, rv_reg, rv_next;
  logic [1:0]         br_reg, br_next, rr_reg, rr_next;
  logic [31:0]        rd_reg, rd_next;
  logic               awr_reg, awr_next, wr_reg, wr_next, arr_reg, arr_next;

  logic [ACC_W-1:0]   d_y;
  logic               d_ovf;
  logic [ADDR_UW-1:0] a_y;
  logic               do_write;
  int                 widx, ridx;

  // (RULE_03) data unit clamps when enabled
  aos_sat_add #(.W(ACC_W)) u_dsat (
    .a      (acc_reg[d_op_acc]),
    .b      (d_op_operand),
    .sub    (d_op_sub),
    .sat_en (ctrl_reg[CTRL_DSAT_BIT]),
    .y      (d_y),
    .ovf    (d_ovf)
  );

  // (RULE_05) address unit clamps only when enabled
  // Its overflow output stays open: address results must never raise a flag
  aos_sat_add #(.W(ADDR_UW)) u_asat (
    .a      (a_op_a),
    .b      (a_op_b),
    .sub    (a_op_sub),
    .sat_en (ctrl_reg[CTRL_ASAT_BIT]),
    .y      (a_y),
    .ovf    ()
  );

  // Datapath and register file next state; a bus write and an overflow in
  // the same cycle both land, with the overflow set beating the clear
  always_comb
  begin
    do_write   = awh_reg && wh_reg && !bv_reg;
    widx       = acc_word(awa_reg);
    ridx       = acc_word(s_axi_araddr);
    ctrl_next  = ctrl_reg;
    flags_next = flags_reg;
    for (int i = 0; i < NUM_ACC; i++)
      acc_next[i] = acc_reg[i];
    // (RULE_01) full 40-bit guarded accumulator update
    if (d_op_valid)
      acc_next[d_op_acc] = d_op_load ? d_op_operand : d_y;
    // Address result is registered; no flag is touched for it
    aval_next = a_op_valid;
    ares_next = a_op_valid ? a_y : ares_reg;
    // Write channel capture, either order
    awh_next  = awh_reg;
    wh_next   = wh_reg;
    awa_next  = awa_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    if (s_axi_awvalid && awr_reg)
    begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg)
    begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (bv_reg && s_axi_bready)
      bv_next = 1'b0;
    if (do_write)
    begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = RESP_OKAY;
      if (awa_reg == OFF_CTRL)
      begin
        if (ws_reg[0])
          ctrl_next = wd_reg[1:0];
      end
      else if (awa_reg == OFF_FLAGS)
      begin
        // (RULE_07) write one to clear
        if (ws_reg[0])
          flags_next = flags_reg & ~wd_reg[NUM_ACC-1:0];
      end
      else if (widx < 0)
        br_next = RESP_DECERR;
    end
    // (RULE_02) per-accumulator flag
    // (RULE_04) set regardless of saturation enable
    if (d_op_valid && !d_op_load && d_ovf)
      flags_next[d_op_acc] = 1'b1;
    awr_next = !awh_next;
    wr_next  = !wh_next;
    // Read channel: one outstanding read, answered a cycle after address
    rv_next  = rv_reg;
    rr_next  = rr_reg;
    rd_next  = rd_reg;
    if (rv_reg && s_axi_rready)
      rv_next = 1'b0;
    if (s_axi_arvalid && arr_reg)
    begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      rd_next = 32'h0000_0000;
      if (s_axi_araddr == OFF_CTRL)
        rd_next = {30'h0000_0000, ctrl_reg};
      else if (s_axi_araddr == OFF_FLAGS)
        rd_next = {28'h000_0000, flags_reg};
      else if (ridx >= 0 && ridx[0])
        rd_next = {24'h00_0000, acc_reg[ridx >> 1][ACC_W-1:BODY_W]};
      else if (ridx >= 0)
        rd_next = acc_reg[ridx >> 1][BODY_W-1:0];
      else
        rr_next = RESP_DECERR;
    end
    arr_next = !rv_next;
  end

  // State registers, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_ACC; i++)
        acc_reg[i] <= ACC_RST;
      flags_reg <= FLAGS_RST;
      ctrl_reg  <= CTRL_RST;
      ares_reg  <= 16'h0000;
      aval_reg  <= 1'b0;
      awh_reg   <= 1'b0;
      wh_reg    <= 1'b0;
      awa_reg   <= 8'h00;
      wd_reg    <= 32'h0000_0000;
      ws_reg    <= 4'h0;
      bv_reg    <= 1'b0;
      br_reg    <= RESP_OKAY;
      rv_reg    <= 1'b0;
      rr_reg    <= RESP_OKAY;
      rd_reg    <= 32'h0000_0000;
      awr_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      arr_reg   <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_ACC; i++)
        acc_reg[i] <= acc_next[i];
      flags_reg <= flags_next;
      ctrl_reg  <= ctrl_next;
      ares_reg  <= ares_next;
      aval_reg  <= aval_next;
      awh_reg   <= awh_next;
      wh_reg    <= wh_next;
      awa_reg   <= awa_next;
      wd_reg    <= wd_next;
      ws_reg    <= ws_next;
      bv_reg    <= bv_next;
      br_reg    <= br_next;
      rv_reg    <= rv_next;
      rr_reg    <= rr_next;
      rd_reg    <= rd_next;
      awr_reg   <= awr_next;
      wr_reg    <= wr_next;
      arr_reg   <= arr_next;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready  = awr_reg;
  assign s_axi_wready   = wr_reg;
  assign s_axi_bvalid   = bv_reg;
  assign s_axi_bresp    = br_reg;
  assign s_axi_arready  = arr_reg;
  assign s_axi_rvalid   = rv_reg;
  assign s_axi_rdata    = rd_reg;
  assign s_axi_rresp    = rr_reg;
  assign a_result_valid = aval_reg;
  assign a_result       = ares_reg;
  assign acc_overflow   = flags_reg;
endmodule // aos_core

`default_nettype wire

//--- aos_core_props.sv
// Purpose: Assertions on the aos_core ports
// Assumes: One clock, synchronous active-low reset
// Notes: The address sum is rebuilt here so that clamping can be judged
`timescale 1ns/100ps
`default_nettype none
module aos_core_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Operations and status
  input wire logic        d_op_valid,
  input wire logic [1:0]  d_op_acc,
  input wire logic        d_op_load,
  input wire logic        a_op_valid,
  input wire logic        a_op_sub,
  input wire logic [15:0] a_op_a,
  input wire logic [15:0] a_op_b,
  input wire logic        a_result_valid,
  input wire logic [15:0] a_result,
  input wire logic [3:0]  acc_overflow
);
  logic [15:0] bx;
  logic [15:0] s;
  logic        ovp;
  logic        ovn;
  // Subtract is an add of the complement, so one overflow test serves both
  always_comb
  begin
    bx  = a_op_sub ? ~a_op_b : a_op_b;
    s   = a_op_a + bx + 16'(a_op_sub);
    ovp = !a_op_a[15] && !bx[15] && s[15];
    ovn = a_op_a[15] && bx[15] && !s[15];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_wresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_addr_pulse: assert property (a_op_valid |=> a_result_valid)
    else $error("address result missing");
  a_addr_hold: assert property (!a_op_valid |=> !a_result_valid && $stable(a_result))
    else $error("address result moved");
  a_addr_exact: assert property (a_op_valid && !ovp && !ovn |=> a_result == $past(s))
    else $error("address result wrong");
  a_addr_limit: assert property (a_op_valid && (ovp || ovn) |=> a_result == $past(s)
    || a_result == ($past(ovp) ? 16'h7FFF : 16'h8000)) else $error("address clamp wrong");
  a_flag_source: assert property ((acc_overflow & ~$past(acc_overflow)) != 4'h0
    |-> $past(d_op_valid && !d_op_load)
    && (acc_overflow & ~$past(acc_overflow)) == (4'h1 << $past(d_op_acc)))
    else $error("flag raised without own overflow");
  a_flag_sticky: assert property ((|($past(acc_overflow) & ~acc_overflow))
    |-> ##[0:1] s_axi_bvalid) else $error("flag cleared without write");
  // Main scenarios reached
  cover property (a_op_valid && ovp);
  cover property ($rose(acc_overflow[3]));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // aos_core_props
bind aos_core aos_core_props u_props (.*);
`default_nettype wire

//--- aos_core_tb.sv
// Purpose: Self-checking bench for aos_core
// Assumes: Bus answers arrive within the watchdog limit
// Notes: Expected values are worked out from the saturation rules
`timescale 1ns/100ps
`default_nettype none
module aos_core_tb;
  import aos_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic d_op_valid, d_op_load, d_op_sub, a_op_valid, a_op_sub, a_result_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, acc_overflow;
  logic [1:0] s_axi_bresp, s_axi_rresp, d_op_acc;
  logic [ACC_W-1:0] d_op_operand;
  logic [15:0] a_op_a, a_op_b, a_result;
  int failures, n_compared, wd;
  aos_core DUT (.*);
  task automatic summarize();
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask
  // Both words of one accumulator; guard bits sit in the low byte of the high word
  task automatic racc(input logic [1:0] i, input logic [39:0] e);
    rd(OFF_ACC_LO + 8'(i) * ACC_STRIDE, e[31:0], RESP_OKAY);
    rd(OFF_ACC_HI + 8'(i) * ACC_STRIDE, {24'h000000, e[39:32]}, RESP_OKAY);
  endtask
  task automatic dop(input logic [1:0] i, input logic ld, input logic sb, input logic [39:0] v);
    @(posedge aclk);
    {d_op_valid, d_op_load, d_op_sub} <= {1'b1, ld, sb};
    d_op_acc <= i;
    d_op_operand <= v;
    @(posedge aclk);
    d_op_valid <= 1'b0;
  endtask
  task automatic aop(input logic sb, input logic [15:0] x, input logic [15:0] y,
                     input logic [15:0] e);
    @(posedge aclk);
    {a_op_valid, a_op_sub} <= {1'b1, sb};
    a_op_a <= x;
    a_op_b <= y;
    @(posedge aclk);
    a_op_valid <= 1'b0;
    @(posedge aclk);
    chk(a_result, e);
    chk(a_result_valid, 1'b1);
    rd(OFF_FLAGS, 32'h00000000, RESP_OKAY);
  endtask
  // Clock and watchdog
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    wd = 0;
    forever
    begin
      @(posedge aclk);
      wd++;
      if (wd == 20000)
      begin
        failures++;
        summarize();
      end
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {d_op_valid, d_op_load, d_op_sub, a_op_valid, a_op_sub, d_op_acc} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, d_op_operand, a_op_a, a_op_b} = 0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL, 32'h00000000, RESP_OKAY);
    rd(8'h40, 32'h00000000, RESP_DECERR);
    // body carry lands in the guard bits
    dop(2'h0, 1, 0, 40'h00_FFFF_FFFF);
    dop(2'h0, 0, 0, 40'h00_0000_0001);
    racc(2'h0, 40'h01_0000_0000);
    // wrap with saturation off still flags
    dop(2'h1, 1, 0, 40'h7F_FFFF_FFFF);
    dop(2'h1, 0, 0, 40'h00_0000_0001);
    racc(2'h1, 40'h80_0000_0000);
    rd(OFF_FLAGS, 32'h00000002, RESP_OKAY);
    chk(acc_overflow, 4'h2);
    wr(OFF_CTRL, 32'h00000001);
    dop(2'h2, 1, 0, 40'h80_0000_0000);
    dop(2'h2, 0, 1, 40'h00_0000_0001);
    racc(2'h2, 40'h80_0000_0000);
    dop(2'h3, 1, 0, 40'h7F_FFFF_FFFF);
    dop(2'h3, 0, 0, 40'h7F_FFFF_FFFF);
    racc(2'h3, 40'h7F_FFFF_FFFF);
    dop(2'h0, 0, 0, 40'h00_0000_0001);
    rd(OFF_FLAGS, 32'h0000000E, RESP_OKAY);
    wr(OFF_FLAGS, 32'h00000002);
    rd(OFF_FLAGS, 32'h0000000C, RESP_OKAY);
    wr(OFF_FLAGS, 32'h0000000F);
    rd(OFF_FLAGS, 32'h00000000, RESP_OKAY);
    // address unit wraps, then clamps once enabled
    aop(0, 16'h7FFF, 16'h0001, 16'h8000);
    wr(OFF_CTRL, 32'h00000003);
    rd(OFF_CTRL, 32'h00000003, RESP_OKAY);
    aop(0, 16'h7FFF, 16'h0001, 16'h7FFF);
    aop(1, 16'h8000, 16'h0001, 16'h8000);
    aop(1, 16'h0005, 16'h0007, 16'hFFFE);
    summarize();
  end
endmodule // aos_core_tb
`default_nettype wire

//--- aos_sat_add.sv
// Purpose : Package for the accumulator overflow and saturation block, and
//           the shared add/subtract unit with overflow detect and clamp.
// Assumes : Operands are two's complement of width W.
// Notes   : The adder is combinational; the caller registers the result.

`timescale 1ns/100ps
`default_nettype none

package aos_pkg;
  // Accumulator layout: 32-bit body plus 8 guard bits
  localparam int unsigned BODY_W   = 32;
  localparam int unsigned GUARD_W  = 8;
  localparam int unsigned ACC_W    = BODY_W + GUARD_W;
  localparam int unsigned NUM_ACC  = 4;
  localparam int unsigned ADDR_UW  = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FLAGS   = 8'h04;
  localparam logic [7:0] OFF_ACC_LO  = 8'h10;
  localparam logic [7:0] OFF_ACC_HI  = 8'h14;
  localparam logic [7:0] ACC_STRIDE  = 8'h08;
  // Control field positions
  localparam int unsigned CTRL_DSAT_BIT = 0;
  localparam int unsigned CTRL_ASAT_BIT = 1;
  // Reset values
  localparam logic [1:0]       CTRL_RST  = 2'h0;
  localparam logic [3:0]       FLAGS_RST = 4'h0;
  localparam logic [ACC_W-1:0] ACC_RST   = 40'h00_0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : aos_pkg

module aos_sat_add #(
  parameter int unsigned W = 16
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         sub,
  input  wire logic         sat_en,
  // Result
  output logic      [W-1:0] y,
  output logic              ovf
);
  logic [W-1:0] b_eff;
  logic [W:0]   sum;

  // One extra bit holds the true sign; differs from bit W-1 on overflow
  always_comb
  begin
    b_eff = sub ? ~b : b;
    sum   = {a[W-1], a} + {b_eff[W-1], b_eff} + {{W{1'b0}}, sub};
    ovf   = sum[W] ^ sum[W-1];
    y     = sum[W-1:0];
    // (RULE_06) nearest range limit
    if (ovf && sat_en)
      y = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
  end
endmodule // aos_sat_add

`default_nettype wire
